// File: hdl/uart_pkg.sv
// constants, register map and types for the serial port
package uart_pkg;
  localparam int AW = 4;
  // register indices
  localparam logic [3:0] A_STAT = 4'h0;
  localparam logic [3:0] A_CR1 = 4'h1;
  localparam logic [3:0] A_CR2 = 4'h2;
  localparam logic [3:0] A_CR3 = 4'h3;
  localparam logic [3:0] A_DATA = 4'h4;
  localparam logic [3:0] A_BRDH = 4'h5;
  localparam logic [3:0] A_BRDL = 4'h6;
  localparam logic [3:0] A_FCR = 4'h7;
  localparam logic [3:0] A_RXCNT = 4'h8;
  // line_control_one bits
  localparam int C1_EN = 7;
  localparam int C1_BNO = 6;
  localparam int C1_PREN = 5;
  localparam int C1_PRT = 3;
  localparam int C1_BRK = 2;
  localparam int C1_TX8 = 0;
  // line_control_two bits
  localparam int C2_TXEN = 7;
  localparam int C2_RXEN = 6;
  localparam int C2_STOPS = 5;
  localparam int C2_RIE = 2;
  // line_control_three bits
  localparam int C3_SWM = 0;
  localparam int C3_BOTH = 1;
  // reset values and write masks
  localparam logic [7:0] STAT_RST = 8'h0B;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CR1_DIS_MASK = 8'hFB;
  localparam logic [7:0] CR2_DIS_MASK = 8'h3F;
  localparam logic [7:0] CR3_MASK = 8'h03;
  localparam logic [7:0] FCR_MASK = 8'h3F;
  // timing counts
  localparam logic [3:0] OS_LAST = 4'hF;
  localparam logic [3:0] NB8 = 4'h8;
  localparam logic [3:0] NB9 = 4'h9;
  localparam logic [3:0] FRAME_MIN = 4'hA;
  localparam logic [3:0] BRK_BITS = 4'hD;
  localparam logic [2:0] FIFO_DEPTH = 3'h4;
  localparam logic [8:0] MASK8 = 9'h0FF;
  localparam logic [8:0] MASK7 = 9'h07F;
  // parity kinds
  localparam logic [1:0] PAR_EVEN = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_MARK = 2'h2;
  localparam logic [1:0] PAR_SPACE = 2'h3;
  typedef enum {TX_IDLE, TX_SHIFT, TX_BREAK} tx_state_t;
  typedef enum {RX_IDLE, RX_START, RX_DATA} rx_state_t;
endpackage : uart_pkg

// File: hdl/baud_if.sv
// divisor, run and oversample tick between port and baud generator
`timescale 1ns/10ps
interface baud_if;
  logic [15:0] divisor;
  logic run;
  logic tick;
  modport gen (input divisor, input run, output tick);
  modport user (output divisor, output run, input tick);
endinterface : baud_if

// File: hdl/baud_gen.sv
// baud generator, one-cycle tick at sixteen times the bit rate
`timescale 1ns/10ps
module baud_gen (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // divisor and tick
  baud_if.gen bif
);
  logic [15:0] cnt;
  logic tick;
  assign bif.tick = tick;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (!bif.run) begin
      cnt <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt >= bif.divisor) begin
      cnt <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule : baud_gen

// File: hdl/bit_parity.sv
// parity bit for the selected kind over the masked data bits
`timescale 1ns/10ps
module bit_parity (
  // data and selection
  input wire logic [8:0] bits,
  input wire logic [8:0] mask,
  input wire logic [1:0] kind,
  // result
  output logic parity
);
  import uart_pkg::*;
  wire ones_odd = ^(bits & mask);
  assign parity = (kind == PAR_EVEN) ? ones_odd :
                  (kind == PAR_ODD) ? ~ones_odd :
                  (kind == PAR_MARK) ? 1'b1 : 1'b0;
endmodule : bit_parity

// File: hdl/uart_port.sv
// serial port: pins, single-wire sharing, shift paths, status flags
//
// Function
// - clearing port, transmit or receive enable floats the matching pin
// - single-wire with receive enabled: shared pin is the receive input
// - single-wire, receive off, transmit on: drive the shared pin
// - single-wire with both enables set: receive wins, no transmit
// - single-wire transmit may also appear on the dedicated output pin
// - written character goes to hidden shifter, sent lsb first at baud
// - received bits shift in lsb first, then move to the data buffer
// - one data location: writes transmit, reads return received data
// - status is read only; resets to both idles and transmit empty set
// - parity error sets on bad parity; status read then data access
// - noise sets on transfer into the buffer, never on overrun; same clear
// - framing error sets for a bad character; same clear sequence
// - overrun sets on full buffer, blocks further transfers till clear
// - receiver idle is low from start bit detection to stop bit end
// - receive flag sets at trigger level; interrupt when enabled
// - parity, noise and framing errors flag in the same cycle as the receive flag when the trigger level is 1
// - receive flag clears on status read then read leaving buffer empty
// - transmitter idle when buffer empty, nothing sent, output high
// - transmitter idle clears on status read then data write
// - transmit empty sets on transfer to shifter; clears the same way
// - setting transmit enable also sets transmit empty
// - port disable flushes buffers, clears errors, sets idle flags
// - parity type 00 even, 01 odd, 10 mark, 11 space
// - break: finish buffered data, then hold low thirteen bits or more
`timescale 1ns/10ps
module uart_port (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // register port
  input wire logic [uart_pkg::AW-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  // dedicated transmit pin
  output logic serial_out_pin,
  output logic serial_out_pin_oe_n,
  // shared receive/transmit pin
  input wire logic shared_line_pin_in,
  output logic shared_line_pin_out,
  output logic shared_line_pin_oe_n,
  // receive interrupt
  output logic rx_irq
);
  import uart_pkg::*;

  logic [7:0] cr1, cr2, cr3, brdh, brdl, fcr;
  logic perr, nf, ferr, oerr, ridle, rxif, tidle, txif;
  logic seen_err, seen_rxif, seen_tidle, seen_txif, txen_q;
  logic [8:0] tx_buf;
  logic tx_full;
  tx_state_t tx_st;
  logic [11:0] tsh;
  logic [3:0] tbits, tos;
  logic rx_s1, rx_s2;
  rx_state_t rx_st;
  logic [3:0] rx_os, rx_idx;
  logic [2:0] rx_smp;
  logic [9:0] rx_sh;
  logic rx_noise;
  logic [8:0] mem [FIFO_DEPTH];
  logic [1:0] wp, rp;
  logic [2:0] cnt;
  logic tx_par, rx_par;

  // control decode
  wire en = cr1[C1_EN];
  wire bno = cr1[C1_BNO];
  wire pren = cr1[C1_PREN];
  wire brk = cr1[C1_BRK];
  wire txen = cr2[C2_TXEN];
  wire rxen = cr2[C2_RXEN];
  wire swm = cr3[C3_SWM];
  wire [1:0] ptype = cr1[C1_PRT+1:C1_PRT];
  wire [8:0] par_mask = bno ? MASK8 : MASK7;
  wire rx_on = en & rxen;
  wire tx_on = en & txen & ~(swm & rxen);

  // bus decode
  wire hit_data = addr == A_DATA;
  wire wr_cr1 = wr_en & (addr == A_CR1);
  wire wr_cr2 = wr_en & (addr == A_CR2);
  wire data_wr = wr_en & hit_data;
  wire data_rd = rd_en & hit_data;
  wire data_acc = data_wr | data_rd;
  wire stat_rd = rd_en & (addr == A_STAT);
  wire [7:0] next_cr1 = wr_cr1 ? wdata : cr1;
  wire [7:0] next_cr2 = wr_cr2 ? wdata : cr2;

  // baud generator
  baud_if bif ();
  assign bif.divisor = {brdh, brdl};
  assign bif.run = en;
  wire tick = bif.tick;
  baud_gen u_baud (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .bif(bif)
  );

  // control registers; disabling the port clears the enables and break
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cr1 <= CTRL_RST;
      cr2 <= CTRL_RST;
      cr3 <= CTRL_RST;
      brdh <= CTRL_RST;
      brdl <= CTRL_RST;
      fcr <= CTRL_RST;
    end else begin
      cr1 <= next_cr1[C1_EN] ? next_cr1 : next_cr1 & CR1_DIS_MASK;
      cr2 <= next_cr1[C1_EN] ? next_cr2 : next_cr2 & CR2_DIS_MASK;
      if (wr_en && addr == A_CR3) cr3 <= wdata & CR3_MASK;
      if (wr_en && addr == A_BRDH) brdh <= wdata;
      if (wr_en && addr == A_BRDL) brdl <= wdata;
      if (wr_en && addr == A_FCR) fcr <= wdata & FCR_MASK;
    end
  end

  // transmit framing
  wire [8:0] tx_dw = pren ?
    (bno ? {tx_par, tx_buf[7:0]} : {1'b1, tx_par, tx_buf[6:0]}) :
    (bno ? tx_buf : {1'b1, tx_buf[7:0]});
  wire [11:0] tx_frame = {2'b11, tx_dw, 1'b0};
  wire [3:0] tx_nbits = FRAME_MIN + {3'b000, bno} +
    {3'b000, cr2[C2_STOPS]};
  wire tx_load = tx_on & (tx_st == TX_IDLE) & tx_full;
  wire tx_busy = tx_full | (tx_st != TX_IDLE);
  wire tx_line = (tx_st == TX_BREAK) ? 1'b0 : tsh[0];

  bit_parity u_tx_par (
    .bits(tx_buf),
    .mask(par_mask),
    .kind(ptype),
    .parity(tx_par)
  );

  // one-character transmit buffer; a write while disabled is dropped
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_buf <= 9'h000;
      tx_full <= 1'b0;
    end else if (!tx_on) begin
      tx_full <= 1'b0;
    end else if (data_wr) begin
      tx_buf <= {cr1[C1_TX8], wdata};
      tx_full <= 1'b1;
    end else if (tx_load) begin
      tx_full <= 1'b0;
    end
  end

  // transmit shifter; buffered data always goes before a break
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tx_st <= TX_IDLE;
      tsh <= 12'hFFF;
      tbits <= 4'h0;
      tos <= 4'h0;
    end else if (!tx_on) begin
      tx_st <= TX_IDLE;
      tsh <= 12'hFFF;
    end else begin
      unique case (tx_st)
        TX_IDLE: begin
          if (tx_full) begin
            tsh <= tx_frame;
            tbits <= tx_nbits;
            tos <= 4'h0;
            tx_st <= TX_SHIFT;
          end else if (brk) begin
            tbits <= BRK_BITS;
            tos <= 4'h0;
            tx_st <= TX_BREAK;
          end
        end
        TX_SHIFT: begin
          if (tick) begin
            tos <= tos + 4'h1;
            if (tos == OS_LAST) begin
              tsh <= {1'b1, tsh[11:1]};
              tbits <= tbits - 4'h1;
              if (tbits == 4'h1) tx_st <= TX_IDLE;
            end
          end
        end
        TX_BREAK: begin
          if (tick) tos <= tos + 4'h1;
          if (tick && tos == OS_LAST && tbits != 4'h0) begin
            tbits <= tbits - 4'h1;
          end
          if (!brk && tbits == 4'h0) tx_st <= TX_IDLE;
        end
      endcase
    end
  end

  // receive input always arrives on the shared pin
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end else begin
      rx_s1 <= shared_line_pin_in;
      rx_s2 <= rx_s1;
    end
  end

  // three mid-bit samples vote; disagreement in the start bit or a data bit counts as noise
  wire rx_maj = (rx_smp[0] & rx_smp[1]) | (rx_smp[0] & rx_smp[2]) |
    (rx_smp[1] & rx_smp[2]);
  wire rx_odd = ~(&rx_smp) & (|rx_smp);
  wire rx_mid = (rx_os == 4'h7) | (rx_os == 4'h8) | (rx_os == 4'h9);
  wire [3:0] rx_nbits = bno ? NB9 : NB8;
  wire rx_done = rx_on & tick & (rx_st == RX_DATA) & (rx_os == OS_LAST) &
    (rx_idx == rx_nbits);
  wire [8:0] rx_word = bno ? rx_sh[8:0] : {1'b0, rx_sh[7:0]};
  wire rx_pbit = bno ? rx_sh[8] : rx_sh[7];
  wire [8:0] rx_store = pren ? (rx_word & par_mask) : rx_word;
  wire pe_bad = pren & (rx_par != rx_pbit);

  bit_parity u_rx_par (
    .bits(rx_word),
    .mask(par_mask),
    .kind(ptype),
    .parity(rx_par)
  );

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rx_st <= RX_IDLE;
      rx_os <= 4'h0;
      rx_idx <= 4'h0;
      rx_smp <= 3'h7;
      rx_sh <= 10'h000;
      rx_noise <= 1'b0;
      ridle <= 1'b1;
    end else if (!rx_on) begin
      rx_st <= RX_IDLE;
      ridle <= 1'b1;
    end else if (tick) begin
      if (rx_mid) rx_smp <= {rx_s2, rx_smp[2:1]};
      unique case (rx_st)
        RX_IDLE: begin
          if (!rx_s2) begin
            rx_st <= RX_START;
            rx_os <= 4'h1;
            ridle <= 1'b0;
          end
        end
        RX_START: begin
          rx_os <= rx_os + 4'h1;
          if (rx_os == OS_LAST) begin
            rx_idx <= 4'h0;
            rx_noise <= rx_odd;
            if (rx_maj) begin
              rx_st <= RX_IDLE;
              ridle <= 1'b1;
            end else begin
              rx_st <= RX_DATA;
            end
          end
        end
        RX_DATA: begin
          rx_os <= rx_os + 4'h1;
          if (rx_os == OS_LAST) begin
            rx_sh[rx_idx] <= rx_maj;
            rx_noise <= rx_noise | rx_odd;
            rx_idx <= rx_idx + 4'h1;
            if (rx_idx == rx_nbits) begin
              rx_st <= RX_IDLE;
              ridle <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // four-entry receive buffer
  wire fifo_full = cnt == FIFO_DEPTH;
  wire push = rx_done & ~fifo_full & ~oerr;
  wire ovr_set = rx_done & (fifo_full | oerr);
  wire pop = data_rd & (cnt != 3'h0);
  wire [2:0] next_cnt = cnt + {2'b00, push} - {2'b00, pop};
  wire [2:0] trig_lvl = {1'b0, fcr[1:0]} + 3'h1;
  wire [8:0] head = mem[rp];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wp <= 2'h0;
      rp <= 2'h0;
      cnt <= 3'h0;
    end else if (!rx_on) begin
      wp <= 2'h0;
      rp <= 2'h0;
      cnt <= 3'h0;
    end else begin
      if (push) begin
        mem[wp] <= rx_store;
        wp <= wp + 2'h1;
      end
      if (pop) rp <= rp + 2'h1;
      cnt <= next_cnt;
    end
  end

  // status flags; a set in the cycle of a clear wins
  wire err_clr = seen_err & data_acc;
  wire rx_trig = push & (next_cnt >= trig_lvl);
  wire rxif_clr = seen_rxif & data_rd & (next_cnt == 3'h0);
  wire txif_clr = seen_txif & data_wr;
  wire tidle_clr = seen_tidle & data_wr;
  wire txen_rise = txen & ~txen_q;
  wire tx_quiet = txif & ~tx_busy & ~brk;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      {perr, nf, ferr, oerr, rxif} <= 5'h00;
      tidle <= STAT_RST[1];
      txif <= STAT_RST[0];
      {seen_err, seen_rxif, seen_tidle, seen_txif} <= 4'h0;
      txen_q <= 1'b0;
    end else if (!en) begin
      {perr, nf, ferr, oerr, rxif} <= 5'h00;
      tidle <= 1'b1;
      txif <= 1'b1;
      {seen_err, seen_rxif, seen_tidle, seen_txif} <= 4'h0;
      txen_q <= 1'b0;
    end else begin
      perr <= (push & pe_bad) | (perr & ~err_clr);
      nf <= (push & rx_noise) | (nf & ~err_clr);
      ferr <= (push & ~rx_maj) | (ferr & ~err_clr);
      oerr <= ovr_set | (oerr & ~err_clr);
      rxif <= rx_on & (rx_trig | (rxif & ~rxif_clr));
      txif <= tx_load | txen_rise | (txif & ~txif_clr);
      tidle <= tx_quiet | (tidle & ~tidle_clr & ~tx_busy);
      txen_q <= txen;
      if (stat_rd) begin
        seen_err <= 1'b1;
        seen_rxif <= rxif;
        seen_tidle <= tidle;
        seen_txif <= txif;
      end else if (data_acc) begin
        {seen_err, seen_rxif, seen_tidle, seen_txif} <= 4'h0;
      end
    end
  end

  // read path: status is read only, writes to it are ignored
  wire [7:0] stat = {perr, nf, ferr, oerr, ridle, rxif, tidle, txif};
  wire [7:0] rd_mux = (addr == A_STAT) ? stat :
    (addr == A_CR1) ? {cr1[7:2], head[8], 1'b0} :
    (addr == A_CR2) ? cr2 :
    (addr == A_CR3) ? cr3 :
    hit_data ? head[7:0] :
    (addr == A_BRDH) ? brdh :
    (addr == A_BRDL) ? brdl :
    (addr == A_FCR) ? fcr :
    (addr == A_RXCNT) ? {5'h00, cnt} : 8'h00;

  // pins, registered so the outputs never glitch
  wire next_so_oe_n = ~(tx_on & (~swm | cr3[C3_BOTH]));
  wire next_sl_oe_n = ~(tx_on & swm);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
      serial_out_pin <= 1'b1;
      serial_out_pin_oe_n <= 1'b1;
      shared_line_pin_out <= 1'b1;
      shared_line_pin_oe_n <= 1'b1;
      rx_irq <= 1'b0;
    end else begin
      rdata <= rd_en ? rd_mux : 8'h00;
      serial_out_pin <= tx_line;
      serial_out_pin_oe_n <= next_so_oe_n;
      shared_line_pin_out <= tx_line;
      shared_line_pin_oe_n <= next_sl_oe_n;
      rx_irq <= rxif & cr2[C2_RIE];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  chk_pins_release: assert property (!en |=>
    serial_out_pin_oe_n && shared_line_pin_oe_n)
    else $error("pins driven while port disabled");
  chk_sw_drive: assert property (en && swm && txen && !rxen |=>
    !shared_line_pin_oe_n && shared_line_pin_out == $past(tx_line))
    else $error("shared pin not driven in single-wire transmit");
  chk_sw_priority: assert property (swm && rxen |=>
    shared_line_pin_oe_n && serial_out_pin_oe_n)
    else $error("transmit active while receive has priority");
  chk_load_empty: assert property (tx_load && !data_wr |=>
    txif && !tx_full)
    else $error("transmit empty not set on transfer");
  chk_txen_empty: assert property (en && $rose(txen) |=> txif)
    else $error("transmit enable did not set transmit empty");
  chk_err_with_rx: assert property (push && !rx_maj && fcr[1:0] == 2'h0
    && !err_clr |=> ferr && rxif)
    else $error("framing error not flagged with receive flag");
  chk_ovr_block: assert property (oerr |=> cnt <= $past(cnt))
    else $error("transfer into buffer during overrun");
  chk_ridle_busy: assert property (rx_st != RX_IDLE |-> !ridle)
    else $error("receiver idle while receiving");
  chk_break_hold: assert property (tx_on && tx_st == TX_BREAK &&
    tbits != 4'h0 |=> tx_st == TX_BREAK && serial_out_pin == 1'b0)
    else $error("break ended before thirteen bits");
  chk_disable_flags: assert property (!en |=>
    ridle && tidle && txif && !rxif && !oerr && cnt == 3'h0)
    else $error("disable did not reset the flags");
  chk_tidle_busy: assert property (en && tx_busy |=> !tidle)
    else $error("transmitter idle set while busy");

  cov_tx_frame: cover property (tx_load ##[1:300] tx_st == TX_IDLE);
  cov_rx_push: cover property (push);
  cov_break: cover property (tx_st == TX_BREAK && tbits == 4'h0);
  cov_overrun: cover property (ovr_set);
endmodule : uart_port

// File: bench/serial_partner.sv
// far-side serial device: frame sender and frame capturer
`timescale 1ns/10ps
module serial_partner #(
  parameter int BIT_CYC = 16
) (
  // clock
  input wire logic ref_clk,
  // line watched and line driven
  input wire logic watch,
  output logic drv,
  output logic drv_oe_n
);
  initial begin
    drv = 1'b0;
    drv_oe_n = 1'b1;
  end

  // start low, n bits lsb first, one stop at the given level
  task automatic send(input logic [8:0] bits, input int n,
    input logic stop);
    @(posedge ref_clk);
    drv_oe_n <= 1'b0;
    drv <= 1'b0;
    repeat (BIT_CYC) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      drv <= bits[i];
      repeat (BIT_CYC) @(posedge ref_clk);
    end
    drv <= stop;
    repeat (BIT_CYC) @(posedge ref_clk);
    // released: the pull-up decides, the old value must not linger
    drv_oe_n <= 1'b1;
    drv <= ~stop;
  endtask : send

  // waits for a start bit, samples n bits and the stop at mid-bit
  task automatic recv(input int n, output logic [9:0] got);
    int w;
    got = '0;
    w = 0;
    while (watch !== 1'b0 && w < 4000) begin
      @(posedge ref_clk);
      w++;
    end
    repeat (BIT_CYC / 2) @(posedge ref_clk);
    for (int i = 0; i <= n; i++) begin
      repeat (BIT_CYC) @(posedge ref_clk);
      got[i] = watch;
    end
  endtask : recv
endmodule : serial_partner

// File: bench/uart_pins_single_wire_status_tb.sv
// testbench for the serial port: register tasks and line scenarios
`timescale 1ns/10ps
module uart_pins_single_wire_status_tb;
  import uart_pkg::*;
  localparam int BC = 16;
  // parity bit of data 05 for even, odd, mark, space
  localparam logic [3:0] PB = 4'b0110;
  logic ref_clk, nrst, wr_en, rd_en, rx_irq;
  logic [AW-1:0] addr;
  logic [7:0] wdata, rdata, st, d;
  logic serial_out_pin, serial_out_pin_oe_n;
  logic shared_line_pin_out, shared_line_pin_oe_n;
  logic p_drv, p_oe_n, on_shared, line, watch, glitch;
  logic [9:0] got;
  int fail_count, checks_done;

  // pull-ups hold both pins high when nobody drives
  assign line = !shared_line_pin_oe_n ? shared_line_pin_out :
    (!p_oe_n ? p_drv ^ glitch : 1'b1);
  assign watch = on_shared ? line :
    (!serial_out_pin_oe_n ? serial_out_pin : 1'b1);

  uart_port uart_port_inst (
    .ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .serial_out_pin(serial_out_pin),
    .serial_out_pin_oe_n(serial_out_pin_oe_n),
    .shared_line_pin_in(line),
    .shared_line_pin_out(shared_line_pin_out),
    .shared_line_pin_oe_n(shared_line_pin_oe_n), .rx_irq(rx_irq)
  );
  serial_partner #(.BIT_CYC(BC)) serial_partner_inst (
    .ref_clk(ref_clk), .watch(watch), .drv(p_drv), .drv_oe_n(p_oe_n)
  );

  always #5 ref_clk = ~ref_clk;

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask : rd

  task automatic cmp(input string what, input logic [7:0] exp,
    input logic [7:0] seen);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : cmp

  task automatic stat(input logic [7:0] m, input logic [7:0] e);
    rd(A_STAT, st);
    cmp("line_status", e, st & m);
  endtask : stat

  // send a character and capture it on the watched pin
  task automatic tx_chk(input logic [7:0] v);
    fork
      serial_partner_inst.recv(8, got);
      begin
        rd(A_STAT, st);
        wr(A_DATA, v);
        stat(8'h02, 8'h00);
      end
    join
    cmp("tx data", v, got[7:0]);
    cmp("tx stop", 8'h01, {7'h0, got[8]});
  endtask : tx_chk

  task automatic rx_frame(input logic [8:0] b, input logic stop);
    serial_partner_inst.send(b, 8, stop);
    repeat (4) @(posedge ref_clk);
  endtask : rx_frame

  task automatic end_sim;
    if (fail_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // hang guard, well above the few thousand cycles the run needs
  initial begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    end_sim();
  end

  initial begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    addr = '0;
    wdata = '0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    on_shared = 1'b0;
    glitch = 1'b0;
    fail_count = 0;
    checks_done = 0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    stat(8'hFF, STAT_RST);
    cmp("oe_n", 8'h03, {6'h0, serial_out_pin_oe_n, shared_line_pin_oe_n});
    wr(A_STAT, 8'h00);
    stat(8'hFF, STAT_RST);
    rd(4'hD, d);
    cmp("unmapped", 8'h00, d);
    // full duplex transmit
    wr(A_CR1, 8'h80);
    // empty flag cleared first, so only the enable can set it again
    rd(A_STAT, st);
    wr(A_DATA, 8'h00);
    stat(8'h01, 8'h00);
    wr(A_CR2, 8'h80);
    stat(8'h01, 8'h01);
    tx_chk(8'hA5);
    cmp("tx oe_n", 8'h00, {7'h0, serial_out_pin_oe_n});
    repeat (2 * BC) @(posedge ref_clk);
    stat(8'h03, 8'h03);
    // break holds the line low at least thirteen bits
    wr(A_CR1, 8'h84);
    repeat (2 * BC) @(posedge ref_clk);
    stat(8'h02, 8'h00);
    wr(A_CR1, 8'h80);
    repeat (10 * BC) @(posedge ref_clk);
    cmp("break", 8'h00, {7'h0, serial_out_pin});
    repeat (4 * BC) @(posedge ref_clk);
    cmp("break end", 8'h01, {7'h0, serial_out_pin});
    // receive with interrupt enable
    wr(A_CR2, 8'h44);
    fork
      rx_frame(9'h03C, 1'b1);
      begin
        repeat (4 * BC) @(posedge ref_clk);
        stat(8'h08, 8'h00);
      end
    join
    stat(8'hFC, 8'h0C);
    cmp("rx_irq", 8'h01, {7'h0, rx_irq});
    rd(A_DATA, d);
    cmp("rx data", 8'h3C, d);
    stat(8'h04, 8'h00);
    cmp("rx_irq off", 8'h00, {7'h0, rx_irq});
    // every parity kind, right bit then wrong bit
    for (int k = 0; k < 4; k++) begin
      wr(A_CR1, {3'b101, k[1:0], 3'b000});
      for (int e = 0; e < 2; e++) begin
        rx_frame({1'b0, PB[k] ^ e[0], 7'h05}, 1'b1);
        stat(8'h80, {e[0], 7'h00});
        rd(A_DATA, d);
        cmp("parity data", 8'h05, d);
      end
    end
    wr(A_CR1, 8'h80);
    rx_frame(9'h055, 1'b0);
    stat(8'h64, 8'h24);
    rd(A_DATA, d);
    stat(8'h20, 8'h00);
    // one bad sample in mid bit 0: noise flagged, vote keeps the data
    fork
      rx_frame(9'h055, 1'b1);
      begin
        repeat (25) @(posedge ref_clk);
        glitch <= 1'b1;
        @(posedge ref_clk);
        glitch <= 1'b0;
      end
    join
    stat(8'h64, 8'h44);
    rd(A_DATA, d);
    cmp("noisy data", 8'h55, d);
    // five characters into a four-deep buffer
    for (int i = 1; i < 6; i++) begin
      rx_frame(9'(i), 1'b1);
    end
    stat(8'h54, 8'h14);
    for (int i = 1; i < 5; i++) begin
      rd(A_DATA, d);
      cmp("overrun data", 8'(i), d);
      stat(8'h10, 8'h00);
    end
    stat(8'h04, 8'h00);
    // single wire: transmit on the shared pin, then also on the other
    wr(A_CR3, 8'h01);
    wr(A_CR2, 8'h80);
    on_shared = 1'b1;
    tx_chk(8'h96);
    cmp("sw out oe_n", 8'h01, {7'h0, serial_out_pin_oe_n});
    wr(A_CR3, 8'h03);
    tx_chk(8'h69);
    cmp("both oe_n", 8'h00, {7'h0, serial_out_pin_oe_n});
    // both enables: receive wins, the write is dropped
    wr(A_CR2, 8'hC0);
    wr(A_DATA, 8'hFF);
    repeat (4) @(posedge ref_clk);
    cmp("rx wins oe_n", 8'h01, {7'h0, shared_line_pin_oe_n});
    stat(8'h02, 8'h02);
    rx_frame(9'h05A, 1'b1);
    rd(A_DATA, d);
    cmp("shared rx", 8'h5A, d);
    // disable with an error pending
    rx_frame(9'h0AA, 1'b0);
    rd(A_RXCNT, d);
    cmp("fill count", 8'h01, d);
    wr(A_CR1, 8'h00);
    stat(8'hFF, STAT_RST);
    rd(A_CR2, d);
    cmp("enables", 8'h00, d & 8'hC0);
    rd(A_RXCNT, d);
    cmp("fill cleared", 8'h00, d);
    cmp("off oe_n", 8'h03, {6'h0, serial_out_pin_oe_n, shared_line_pin_oe_n});
    end_sim();
  end
endmodule : uart_pins_single_wire_status_tb
